// file: pkg/cfgsp_pkg.sv
// Purpose: constants and types of the serial configuration write port
// Assumes: 20 MHz system clock samples the host pins
// Notes: all offsets are byte addresses on the AHB-Lite slave
// Function
// (RULE1) all three control pins high means idle
// (RULE2) select low lends shared pins to port
// (RULE3) select high forces serial clock high
// (RULE4) undriven inputs read high, high is inactive
// (RULE5) data sampled on leading clock edge
// (RULE6) first bit starts at first clock activation
// (RULE7) each writable bit has 6-bit address
// (RULE8) eight bits msb first: data, address, spare
// (RULE9) eighth clock pulse strobes data into latch
// (RULE10) port logic reset only by power-on
// (RULE11) host waits over 30ns before writing
// (RULE12) host clock period longer than 10us; the bench host model clocks at a 400 ns period
// (RULE13) mode bits use same command format
// (RULE14) several commands per active select period
// (RULE15) host clears latches, sets source, powers
// (RULE16) host sets latch, pulses write enable
// (RULE17) host removes supply, then clears source
// (RULE18) lock programming in one select period
// (RULE19) lock takes effect on select release
// (RULE20) mode signals volatile, cleared on reset
// (RULE21) write enable also writes one-time element
// (RULE22) source select picks one-time or shadow
// (RULE23) bit counter cleared on idle, eighth executes
// (RULE24) mode addresses 56, 61, 62; others ignored
// (RULE25) no latch update while sync inactive
package cfgsp_pkg;
  // geometry of the latch space
  localparam int CFG_BITS = 56;
  localparam int ADDR_W = 6;
  localparam int CMD_BITS = 8;
  localparam int VIEW_BYTES = 7;
  // mode signal addresses
  localparam logic [5:0] ADDR_PUMP = 6'h38;
  localparam logic [5:0] ADDR_SRC_SEL = 6'h3d;
  localparam logic [5:0] ADDR_PERM_WE = 6'h3e;
  localparam logic [5:0] FIRST_MODE_ADDR = 6'h38;
  // configuration bit that locks test mode
  localparam int TEST_LOCK_IDX = 0;
  // bit counter value of the execute pulse
  localparam logic [2:0] LAST_BIT = 3'h7;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CFG_LO = 8'h04;
  localparam logic [7:0] OFS_CFG_HI = 8'h08;
  localparam logic [7:0] OFS_VIEW = 8'h0c;
  localparam logic [7:0] OFS_VIEW_DATA = 8'h10;
  localparam logic [7:0] OFS_CMD_COUNT = 8'h14;
  // reset values
  localparam logic [2:0] VIEW_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [55:0] SHADOW_RST = 56'h00_0000_0000_0000;
  // serial port states, gray along idle, armed, shift
  typedef enum logic [1:0] {
    CFGSP_IDLE = 2'b00,
    CFGSP_ARMED = 2'b01,
    CFGSP_SHIFT = 2'b11
  } cfgsp_port_e;

  // true when address names a configuration bit
  function automatic logic cfgsp_is_cfg(input logic [5:0] addr);
    cfgsp_is_cfg = (addr < FIRST_MODE_ADDR);
  endfunction : cfgsp_is_cfg
endpackage : cfgsp_pkg

// file: rtl/cfgsp_latch_bank.sv
// Purpose: shadow latch bank with bit write and byte view
// Assumes: single writer, same clock as the port logic
// Notes: view byte comes out of a register, one cycle late
`timescale 1ns/1ps
module cfgsp_latch_bank
  import cfgsp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_wr_en,
  input wire logic [5:0] i_wr_addr,
  input wire logic i_wr_data,
  input wire logic [2:0] i_view_sel,
  output logic [55:0] o_bits,
  output logic [7:0] o_view_byte
);
  // whole state of the bank
  typedef struct packed {
    logic [55:0] bits;  // shadow latches
    logic [7:0] view;   // registered read byte
  } cfgsp_bank_s;

  cfgsp_bank_s st_r;
  cfgsp_bank_s st_nxt;

  // bit write and byte read
  always_comb begin
    st_nxt = st_r;
    if (i_wr_en && cfgsp_is_cfg(i_wr_addr)) begin
      st_nxt.bits[i_wr_addr] = i_wr_data;
    end
    if (i_view_sel < 3'(VIEW_BYTES)) begin
      st_nxt.view = st_r.bits[i_view_sel*8 +: 8];
    end else begin
      st_nxt.view = 8'h00;
    end
  end

  // power-on clears every latch
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_r <= '{bits: SHADOW_RST, view: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_bits = st_r.bits;
  assign o_view_byte = st_r.view;
endmodule : cfgsp_latch_bank

// file: rtl/cfgsp_top.sv
// Purpose: serial configuration write port with AHB-Lite status view
// Assumes: host pins are asynchronous and slow against i_mclk
// Notes: serial clock is sampled, its falling edge is the leading edge
`timescale 1ns/1ps
module cfgsp_top
  import cfgsp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_config_select_n,
  input wire logic i_sync_strobe_n,
  input wire logic i_serial_clock_in,
  input wire logic i_serial_data_in,
  input wire logic [55:0] i_otp_bits,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [55:0] o_cfg_bits,
  output logic o_pump_mode,
  output logic o_src_select,
  output logic o_perm_write_en,
  output logic o_test_mode_lock,
  output logic o_otp_write_strobe,
  output logic [5:0] o_otp_write_addr,
  output logic o_otp_write_data,
  output logic o_port_owns_pins
);
  // whole state of the port and bus slave
  typedef struct packed {
    logic sel_m;          // select, first sync stage
    logic sel_s;          // select, synced
    logic syn_m;          // sync strobe, first stage
    logic syn_s;          // sync strobe, synced
    logic clk_m;          // serial clock, first stage
    logic clk_s;          // serial clock, synced
    logic sda_m;          // serial data, first stage
    logic sda_s;          // serial data, synced
    logic eff_prev;       // gated clock one sample ago
    logic sel_prev;       // synced select one sample ago
    cfgsp_port_e pstate;  // serial port state
    logic [2:0] bitcnt;   // bits taken of this command
    logic [6:0] shreg;    // data bit and address
    logic pump;           // charge pump drive mode
    logic src_sel;        // shadow latches as source
    logic perm_we;        // permanent write enable
    logic lock;           // test mode lock in force
    logic otp_stb;        // one-time element write pulse
    logic [5:0] otp_addr; // one-time element address
    logic otp_data;       // one-time element data
    logic owns_pins;      // shared pins serve the port
    logic [55:0] cfg_out; // effective configuration
    logic [15:0] cmd_cnt; // executed command count
    logic [2:0] view_sel; // shadow byte on view
    logic dphase;         // bus data phase pending
    logic [7:0] baddr;    // latched bus address
    logic bwrite;         // latched bus direction
    logic ready;          // bus ready out
    logic [31:0] rdata;   // bus read data
  } cfgsp_state_s;

  cfgsp_state_s st_r;
  cfgsp_state_s st_nxt;

  logic [55:0] shadow_bits;  // shadow latch contents
  logic [7:0] view_byte;     // registered shadow byte
  logic eff_clk;             // serial clock after select gating
  logic port_idle;           // all three control pins high
  logic lead_edge;           // falling edge of gated clock
  logic exec;                // execute pulse of a command
  logic [5:0] cmd_addr;      // address of command in flight
  logic cmd_data;            // data bit of command in flight
  logic shadow_wr;           // shadow latch write enable
  logic bus_take;            // bus address phase accepted

  // select high holds the clock high
  assign eff_clk = st_r.sel_s | st_r.clk_s;  // see (RULE3)
  // idle only with select, sync and clock all high
  assign port_idle = st_r.sel_s & st_r.syn_s & eff_clk;  // see (RULE1)
  // leading edge is the clock going active low
  assign lead_edge = st_r.eff_prev & ~eff_clk;  // see (RULE5)
  assign cmd_data = st_r.shreg[6];
  assign cmd_addr = st_r.shreg[5:0];
  // eighth pulse strobes, value of last bit ignored
  assign exec = lead_edge && (st_r.pstate == CFGSP_SHIFT) &&
                (st_r.bitcnt == LAST_BIT) &&
                !st_r.syn_s && !st_r.sel_s;  // see (RULE9) see (RULE25)
  // configuration bits refused once locked
  assign shadow_wr = exec && cfgsp_is_cfg(cmd_addr) &&
                     !st_r.lock;  // see (RULE19) see (RULE7)
  assign bus_take = i_hsel && i_hready && i_htrans[1];

  // shadow latch storage
  cfgsp_latch_bank u_bank (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_wr_en(shadow_wr),
    .i_wr_addr(cmd_addr),
    .i_wr_data(cmd_data),
    .i_view_sel(st_r.view_sel),
    .o_bits(shadow_bits),
    .o_view_byte(view_byte)
  );

  // next state of everything
  always_comb begin
    st_nxt = st_r;
    // two-stage synchronisers for the host pins
    st_nxt.sel_m = i_config_select_n;
    st_nxt.sel_s = st_r.sel_m;
    st_nxt.syn_m = i_sync_strobe_n;
    st_nxt.syn_s = st_r.syn_m;
    st_nxt.clk_m = i_serial_clock_in;
    st_nxt.clk_s = st_r.clk_m;
    st_nxt.sda_m = i_serial_data_in;
    st_nxt.sda_s = st_r.sda_m;
    st_nxt.eff_prev = eff_clk;
    st_nxt.sel_prev = st_r.sel_s;
    // shared pins belong to the port while select is low
    st_nxt.owns_pins = ~st_r.sel_s;  // see (RULE2)
    st_nxt.otp_stb = 1'b0;

    // serial port sequencing
    case (st_r.pstate)
      CFGSP_IDLE: begin
        // leaving idle arms the counter at zero
        st_nxt.bitcnt = 3'h0;  // see (RULE23)
        if (!port_idle) begin
          st_nxt.pstate = CFGSP_ARMED;
        end
      end
      CFGSP_ARMED: begin
        if (port_idle) begin
          st_nxt.pstate = CFGSP_IDLE;
        end else if (lead_edge) begin
          // first activation carries the first bit
          st_nxt.pstate = CFGSP_SHIFT;  // see (RULE6)
          st_nxt.shreg = {st_r.shreg[5:0], st_r.sda_s};
          st_nxt.bitcnt = 3'h1;
        end
      end
      CFGSP_SHIFT: begin
        if (port_idle) begin
          // idle clears any partial command
          st_nxt.pstate = CFGSP_IDLE;
          st_nxt.bitcnt = 3'h0;  // see (RULE23)
        end else if (lead_edge) begin
          if (st_r.bitcnt == LAST_BIT) begin
            // ready for the next command at once
            st_nxt.bitcnt = 3'h0;  // see (RULE14)
          end else begin
            // msb first: data, then address
            st_nxt.shreg = {st_r.shreg[5:0], st_r.sda_s};  // see (RULE8)
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
          end
        end
      end
      default: begin
        st_nxt.pstate = CFGSP_IDLE;
        st_nxt.bitcnt = 3'h0;
      end
    endcase

    // command execution
    if (exec) begin
      st_nxt.cmd_cnt = st_r.cmd_cnt + 16'h0001;
      // mode bits share the command format
      case (cmd_addr)
        ADDR_PUMP: st_nxt.pump = cmd_data;  // see (RULE24) see (RULE13)
        ADDR_SRC_SEL: st_nxt.src_sel = cmd_data;  // see (RULE24)
        ADDR_PERM_WE: st_nxt.perm_we = cmd_data;  // see (RULE24)
        default: begin
          // other addresses change no mode
        end
      endcase
    end
    // permanent write also reaches the one-time element
    if (shadow_wr && st_r.perm_we) begin
      st_nxt.otp_stb = 1'b1;  // see (RULE21)
      st_nxt.otp_addr = cmd_addr;
      st_nxt.otp_data = cmd_data;
    end
    // lock takes hold as select returns to idle
    if (st_r.sel_s && !st_r.sel_prev &&
        st_r.cfg_out[TEST_LOCK_IDX]) begin
      st_nxt.lock = 1'b1;  // see (RULE19)
    end
    // configuration source selection
    st_nxt.cfg_out = st_r.src_sel ? shadow_bits
                                  : i_otp_bits;  // see (RULE22)

    // bus slave, one wait state then answer
    if (st_r.dphase) begin
      st_nxt.dphase = 1'b0;
      st_nxt.ready = 1'b1;
      st_nxt.rdata = RDATA_RST;
      if (st_r.bwrite) begin
        // only the view selector is writable
        if (st_r.baddr == OFS_VIEW) begin
          st_nxt.view_sel = i_hwdata[2:0];
        end
      end else begin
        case (st_r.baddr)
          OFS_STATUS: begin
            st_nxt.rdata = {24'h00_0000, st_r.bitcnt, st_r.owns_pins,
                            st_r.lock, st_r.perm_we, st_r.src_sel,
                            st_r.pump};
          end
          OFS_CFG_LO: st_nxt.rdata = st_r.cfg_out[31:0];
          OFS_CFG_HI: st_nxt.rdata = {8'h00, st_r.cfg_out[55:32]};
          OFS_VIEW: st_nxt.rdata = {29'h0000_0000, st_r.view_sel};
          OFS_VIEW_DATA: st_nxt.rdata = {24'h00_0000, view_byte};
          OFS_CMD_COUNT: st_nxt.rdata = {16'h0000, st_r.cmd_cnt};
          default: st_nxt.rdata = RDATA_RST;
        endcase
      end
    end else if (bus_take) begin
      // address phase accepted, insert one wait state
      st_nxt.dphase = 1'b1;
      st_nxt.ready = 1'b0;
      st_nxt.baddr = i_haddr[7:0];
      st_nxt.bwrite = i_hwrite;
    end
  end

  // power-on reset is the only reset of the port
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin  // see (RULE10)
      st_r <= '0;
      // inputs idle high until sampled, modes cleared
      st_r.sel_m <= 1'b1;  // see (RULE4) see (RULE20)
      st_r.sel_s <= 1'b1;
      st_r.syn_m <= 1'b1;
      st_r.syn_s <= 1'b1;
      st_r.clk_m <= 1'b1;
      st_r.clk_s <= 1'b1;
      st_r.sda_m <= 1'b1;
      st_r.sda_s <= 1'b1;
      st_r.eff_prev <= 1'b1;
      st_r.sel_prev <= 1'b1;
      st_r.pstate <= CFGSP_IDLE;
      st_r.view_sel <= VIEW_RST;
      st_r.ready <= 1'b1;
      st_r.rdata <= RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register, except hresp tied low
  assign o_hrdata = st_r.rdata;
  assign o_hreadyout = st_r.ready;
  assign o_hresp = 1'b0;
  assign o_cfg_bits = st_r.cfg_out;
  assign o_pump_mode = st_r.pump;
  assign o_src_select = st_r.src_sel;
  assign o_perm_write_en = st_r.perm_we;
  assign o_test_mode_lock = st_r.lock;
  assign o_otp_write_strobe = st_r.otp_stb;
  assign o_otp_write_addr = st_r.otp_addr;
  assign o_otp_write_data = st_r.otp_data;
  assign o_port_owns_pins = st_r.owns_pins;

  // checks on the port behaviour
  default clocking cb_mclk @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // select going high after a low period
  sequence s_sel_release;
    !st_r.sel_s ##1 st_r.sel_s;
  endsequence
  // one leading edge while shifting
  sequence s_lead_shift;
    lead_edge && (st_r.pstate != CFGSP_IDLE) && (st_r.bitcnt != LAST_BIT);
  endsequence

  property p_idle_clears;
    port_idle |=> (st_r.bitcnt == 3'h0) && (st_r.pstate != CFGSP_SHIFT);
  endproperty
  a_idle_clears: assert property (p_idle_clears) // see (RULE1)
    else $error("bit count survived idle");

  property p_sel_blocks;
    st_r.sel_s |-> !exec && !lead_edge;
  endproperty
  a_sel_blocks: assert property (p_sel_blocks) // see (RULE3)
    else $error("clock activity while select high");

  property p_exec_eighth;
    exec |-> $past(st_r.bitcnt) == 3'h6 || $past(lead_edge) == 1'b0;
  endproperty
  a_exec_eighth: assert property (p_exec_eighth) // see (RULE23)
    else $error("execute not on eighth pulse");

  property p_sync_gate;
    (lead_edge && st_r.syn_s) |=> $stable(shadow_bits) && !st_r.otp_stb;
  endproperty
  a_sync_gate: assert property (p_sync_gate) // see (RULE25)
    else $error("latch written with sync inactive");

  property p_lock_refuse;
    st_r.lock |=> ##1 $stable(shadow_bits);
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) // see (RULE19)
    else $error("configuration written while locked");

  property p_lock_set;
    (s_sel_release ##0 st_r.cfg_out[TEST_LOCK_IDX]) |=> st_r.lock;
  endproperty
  a_lock_set: assert property (p_lock_set) // see (RULE19)
    else $error("lock not taken on select release");

  property p_mode_pump;
    (exec && cmd_addr == ADDR_PUMP) |=> st_r.pump == $past(cmd_data);
  endproperty
  a_mode_pump: assert property (p_mode_pump) // see (RULE24)
    else $error("pump mode not written");

  property p_perm_strobe;
    (shadow_wr && st_r.perm_we) |=>
      st_r.otp_stb ##1 !st_r.otp_stb;
  endproperty
  a_perm_strobe: assert property (p_perm_strobe) // see (RULE21)
    else $error("one-time write pulse wrong");

  // the edge that leaves reset loads zero, so skip that one
  property p_src_mux;
    !i_reset |=> st_r.cfg_out == ($past(st_r.src_sel) ? $past(shadow_bits)
                                                      : $past(i_otp_bits));
  endproperty
  a_src_mux: assert property (p_src_mux) // see (RULE22)
    else $error("configuration source wrong");

  property p_sample;
    s_lead_shift |=> st_r.shreg[0] == $past(st_r.sda_s);
  endproperty
  a_sample: assert property (p_sample) // see (RULE5)
    else $error("data not sampled on leading edge");

  property p_back_to_back;
    exec |=> (st_r.bitcnt == 3'h0) && (st_r.pstate == CFGSP_SHIFT);
  endproperty
  a_back_to_back: assert property (p_back_to_back) // see (RULE14)
    else $error("port not ready for next command");
endmodule : cfgsp_top

// file: testbench/cfgsp_host_model.sv
// Purpose: host side of the serial configuration write port
// Assumes: bench calls the tasks from one process only
// Notes: pins change just after i_mclk rising edges, 400 ns link clock
`timescale 1ns/1ps
module cfgsp_host_model (
  input wire logic i_mclk,
  output logic o_config_select_n,
  output logic o_sync_strobe_n,
  output logic o_serial_clock_in,
  output logic o_serial_data_in
);
  // undriven pins float high through the pull-ups
  initial begin
    o_config_select_n = 1'b1;
    o_sync_strobe_n = 1'b1;
    o_serial_clock_in = 1'b1;
    o_serial_data_in = 1'b1;
  end

  // plain wait in system clock cycles
  task automatic pause(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : pause

  // leave idle, then enable write after a gap of over 30 ns
  task automatic open_frame(input logic sel_n, input logic sync_n);
    @(posedge i_mclk);
    o_config_select_n <= sel_n;
    pause(2);
    o_sync_strobe_n <= sync_n;
    pause(2);
  endtask : open_frame

  // shift n bits msb first; data moves with the trailing (rising) edge
  task automatic send_bits(input logic [7:0] cmd, input int n);
    for (int i = 0; i < n; i++) begin
      o_serial_data_in <= cmd[7 - i];
      pause(4);
      o_serial_clock_in <= 1'b0;
      pause(4);
      o_serial_clock_in <= 1'b1;
    end
  endtask : send_bits

  // whole command byte
  task automatic send(input logic [7:0] cmd);
    send_bits(cmd, 8);
  endtask : send

  // back to idle; clock stands high between frames
  task automatic close_frame();
    pause(4);
    o_config_select_n <= 1'b1;
    o_sync_strobe_n <= 1'b1;
    o_serial_clock_in <= 1'b1;
    o_serial_data_in <= 1'b1;
    pause(10);
  endtask : close_frame
endmodule : cfgsp_host_model

// file: testbench/tb.sv
// Purpose: self-checking bench of the serial configuration write port
// Assumes: AHB-Lite master with one slave, host model on the pins
// Notes: a bench fuse model turns otp strobes into one-time bits
`timescale 1ns/1ps
module tb;
  import cfgsp_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [55:0] otp_bits = 56'ha5_1234_5678_9abc; // fuse states
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] o_hrdata, rdat_q, d;
  logic o_hreadyout, o_hresp, rdy_q;
  logic [55:0] o_cfg_bits;
  logic o_pump_mode, o_src_select, o_perm_write_en, o_test_mode_lock;
  logic o_otp_write_strobe, o_otp_write_data, o_port_owns_pins;
  logic [5:0] o_otp_write_addr;
  logic sel_n, sync_n, sclk, sdat; // host pins
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int strobes = 0;

  // 20 MHz system clock
  always #25 i_mclk = ~i_mclk;

  cfgsp_host_model i_host (.i_mclk(i_mclk), .o_config_select_n(sel_n),
    .o_sync_strobe_n(sync_n), .o_serial_clock_in(sclk),
    .o_serial_data_in(sdat));

  cfgsp_top i_dut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_config_select_n(sel_n), .i_sync_strobe_n(sync_n),
    .i_serial_clock_in(sclk), .i_serial_data_in(sdat),
    .i_otp_bits(otp_bits), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_cfg_bits(o_cfg_bits), .o_pump_mode(o_pump_mode),
    .o_src_select(o_src_select), .o_perm_write_en(o_perm_write_en),
    .o_test_mode_lock(o_test_mode_lock),
    .o_otp_write_strobe(o_otp_write_strobe),
    .o_otp_write_addr(o_otp_write_addr),
    .o_otp_write_data(o_otp_write_data),
    .o_port_owns_pins(o_port_owns_pins));

  // bus answer settled mid-cycle, equal to what the next edge samples
  always @(negedge i_mclk) begin
    rdy_q = o_hreadyout;
    rdat_q = o_hrdata;
  end

  // fuse model: a strobe with data one blows the addressed element
  always @(posedge i_mclk) begin
    if (o_otp_write_strobe === 1'b1) begin
      strobes <= strobes + 1;
      if (o_otp_write_data === 1'b1) otp_bits[o_otp_write_addr] <= 1'b1;
    end
  end

  // hang guard, far above the real run length
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      complete_run();
    end
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // single word read, waits on hready in both phases
  task automatic ahb_rd(input logic [31:0] a, output logic [31:0] q);
    @(posedge i_mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge i_mclk); while (rdy_q !== 1'b1);
    htrans <= 2'b00;
    do @(posedge i_mclk); while (rdy_q !== 1'b1);
    q = rdat_q;
    hsel <= 1'b0;
  endtask : ahb_rd

  // single word write
  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge i_mclk); while (rdy_q !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge i_mclk); while (rdy_q !== 1'b1);
    hsel <= 1'b0;
  endtask : ahb_wr

  // read a register and compare
  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] q;
    ahb_rd({24'h00_0000, ofs}, q);
    check(q, exp);
  endtask : rd_chk

  // command byte: data, address, ignored execute bit
  function automatic logic [7:0] mk(input logic v, input logic [5:0] a,
                                    input logic x);
    mk = {v, a, x};
  endfunction : mk

  // verdict
  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    repeat (10) @(posedge i_mclk);
    i_reset <= 1'b0;
    // reset state, source select clear shows the fuses
    rd_chk(OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_CFG_LO, 32'h5678_9abc);
    rd_chk(OFS_CFG_HI, 32'h00a5_1234);
    rd_chk(8'h40, 32'h0000_0000);
    // several commands in one period, modes and unused addresses
    i_host.open_frame(1'b0, 1'b0);
    check(o_port_owns_pins, 32'h0000_0001);
    i_host.send(mk(1'b1, ADDR_SRC_SEL, 1'b1));
    i_host.send(mk(1'b1, 6'd52, 1'b0));
    i_host.send(mk(1'b1, ADDR_PUMP, 1'b1));
    i_host.send(mk(1'b1, 6'd57, 1'b0));
    i_host.send(mk(1'b1, 6'd63, 1'b1));
    i_host.close_frame();
    check(o_port_owns_pins, 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0003);
    rd_chk(OFS_CFG_HI, 32'h0010_0000);
    check(strobes, 32'h0000_0000);
    // sync inactive, then select inactive: nothing latches
    i_host.open_frame(1'b0, 1'b1);
    i_host.send(mk(1'b1, 6'd3, 1'b0));
    i_host.close_frame();
    i_host.open_frame(1'b1, 1'b0);
    i_host.send(mk(1'b1, 6'd4, 1'b0));
    i_host.close_frame();
    rd_chk(OFS_CFG_LO, 32'h0000_0000);
    // partial command dropped by idle
    i_host.open_frame(1'b0, 1'b0);
    i_host.send_bits(mk(1'b1, 6'd2, 1'b0), 3);
    i_host.close_frame();
    i_host.open_frame(1'b0, 1'b0);
    i_host.send(mk(1'b1, 6'd1, 1'b1));
    i_host.close_frame();
    rd_chk(OFS_CFG_LO, 32'h0000_0002);
    // shadow byte view and read-only status
    ahb_wr({24'h00_0000, OFS_VIEW}, 32'h0000_0006);
    rd_chk(OFS_VIEW, 32'h0000_0006);
    rd_chk(OFS_VIEW_DATA, 32'h0000_0010);
    ahb_wr({24'h00_0000, OFS_VIEW}, 32'h0000_0000);
    rd_chk(OFS_VIEW_DATA, 32'h0000_0002);
    ahb_wr({24'h00_0000, OFS_STATUS}, 32'hffff_ffff);
    rd_chk(OFS_STATUS, 32'h0000_0003);
    // permanent lock programming within one select period
    i_host.open_frame(1'b0, 1'b0);
    i_host.send(mk(1'b0, 6'd52, 1'b0));
    i_host.send(mk(1'b0, 6'd1, 1'b0));
    i_host.send(mk(1'b1, 6'd0, 1'b0));
    i_host.send(mk(1'b1, ADDR_PERM_WE, 1'b0));
    i_host.pause(8);
    check(o_perm_write_en, 32'h0000_0001);
    i_host.send(mk(1'b1, 6'd0, 1'b0));
    i_host.pause(300);
    i_host.send(mk(1'b0, ADDR_PERM_WE, 1'b0));
    i_host.send(mk(1'b0, 6'd0, 1'b0));
    i_host.send(mk(1'b0, ADDR_SRC_SEL, 1'b0));
    i_host.pause(8);
    check(o_test_mode_lock, 32'h0000_0000);
    i_host.close_frame();
    check(strobes, 32'h0000_0001);
    check(o_otp_write_addr, 32'h0000_0000);
    check(o_otp_write_data, 32'h0000_0001);
    check(o_test_mode_lock, 32'h0000_0001);
    rd_chk(OFS_STATUS, 32'h0000_0009);
    rd_chk(OFS_CFG_LO, 32'h5678_9abd);
    check(o_cfg_bits[31:0], 32'h5678_9abd);
    // locked: mode writes pass, configuration writes refused
    i_host.open_frame(1'b0, 1'b0);
    i_host.send(mk(1'b1, ADDR_SRC_SEL, 1'b0));
    i_host.send(mk(1'b1, 6'd5, 1'b0));
    i_host.close_frame();
    rd_chk(OFS_STATUS, 32'h0000_000b);
    rd_chk(OFS_CFG_LO, 32'h0000_0000);
    check(o_src_select, 32'h0000_0001);
    check(o_pump_mode, 32'h0000_0001);
    check(o_hresp, 32'h0000_0000);
    rd_chk(OFS_CMD_COUNT, 32'h0000_0010);
    // second power-on reset clears modes and lock
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd_chk(OFS_STATUS, 32'h0000_0000);
    rd_chk(OFS_CMD_COUNT, 32'h0000_0000);
    check(o_cfg_bits[31:0], 32'h5678_9abd);
    complete_run();
  end
endmodule : tb
